// ===== design/ext_irq_pkg.sv
// constants, register map and types for the external pin interrupt sense block
package ext_irq_pkg;
  // ***************************
  // bus geometry
  // ***************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_PENDING = 3'h2;
  localparam logic [2:0] ADDR_CORE = 3'h3;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ***************************
  // field positions
  // ***************************
  localparam int SLEEP_ENABLE_BIT = 7;
  localparam int SLEEP_MODE_HI = 6;
  localparam int SLEEP_MODE_LO = 4;
  localparam int PIN_ONE_SENSE_HI = 3;
  localparam int PIN_ONE_SENSE_LO = 2;
  localparam int PIN_ZERO_SENSE_HI = 1;
  localparam int PIN_ZERO_SENSE_LO = 0;
  localparam int PIN_ONE_ENABLE_BIT = 7;
  localparam int PIN_ZERO_ENABLE_BIT = 6;
  localparam int PIN_ONE_PENDING_BIT = 7;
  localparam int PIN_ZERO_PENDING_BIT = 6;
  localparam int GLOBAL_ENABLE_BIT = 7;

  // ***************************
  // encodings
  // ***************************
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  localparam logic [2:0] SLEEP_IDLE = 3'h0;

  // ***************************
  // timing
  // ***************************
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int WDT_PERIOD_NS = 1000;
  localparam int WDT_CYCLES = (WDT_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int STARTUP_CYCLES_DEFAULT = 64;

  typedef enum logic [2:0] {
    ST_AWAKE,
    ST_ASLEEP,
    ST_SAMPLE_ONE,
    ST_SAMPLE_TWO,
    ST_STARTUP
  } wake_state_type;
endpackage

// ===== design/pin_sense_unit.sv
// per-pin synchroniser and edge/change detector
`timescale 1ns/10ps
`default_nettype none
module pin_sense_unit (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_pin,
  input wire logic [1:0] i_sense,
  input wire logic i_io_run,
  output logic o_level,
  output logic o_event
);
  logic meta;
  logic sample;
  logic prev;
  logic changed;
  logic fell;
  logic rose;

  // two-stage synchroniser, then history for comparison
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      meta <= 1'b1;
      sample <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= i_pin;
      sample <= meta; // R12
      prev <= sample; // R19
    end
  end

  // history keeps running while the io clock is gated, so a level change
  // across a stop is never reported late as an edge
  assign changed = sample ^ prev;
  assign fell = prev & ~sample;
  assign rose = ~prev & sample;
  assign o_level = sample;
  assign o_event = i_io_run & // R3
    (((i_sense == ext_irq_pkg::SENSE_ANY) & changed) |
     ((i_sense == ext_irq_pkg::SENSE_FALL) & fell) |
     ((i_sense == ext_irq_pkg::SENSE_RISE) & rose)); // R13

  // ***************************
  // checks
  // ***************************
  event_needs_clock_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R3
    o_event |-> i_io_run) else $error("edge seen with io clock stopped");
  fall_from_samples_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R12
    (o_event && i_sense == ext_irq_pkg::SENSE_FALL) |-> ($past(sample) && !sample))
    else $error("falling event without falling samples");
  no_event_low_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R19
    (i_sense == ext_irq_pkg::SENSE_LOW) |-> !o_event)
    else $error("edge event in low level mode");
endmodule
`default_nettype wire

// ===== design/external_pin_interrupt_sense.sv
// external pin interrupt sense, pending flags, enables and level wake-up
`timescale 1ns/10ps
`default_nettype none
// Function
// [R1] pins are sensed regardless of port direction, enabling software interrupts
// [R2] low level mode keeps requesting while the pin stays low
// [R3] edge and change detection only with the io clock running
// [R4] low level detection works without the io clock, waking any sleep mode
// [R5] io clock stopped in every sleep mode except idle
// [R6] power-down level wake samples the pin twice on the watchdog tick
// [R7] wake when level seen in double sampling or held to startup end
// [R8] level gone before startup end: wake without interrupt
// [R9] pin one sense in control bits 3:2: low, change, fall, rise
// [R10] pin zero sense in control bits 1:0: low, change, fall, rise
// [R11] request reaches core only with global and pin enables set
// [R12] pins sampled into the clock domain before edge detection
// [R13] pulses longer than one clock always produce an edge request
// [R14] source holds a low level until the current instruction completes
// [R15] control register: sleep enable 7, mode 6:4, sense 3:0, reset zero
// [R16] enable register: pin one at bit 7, pin zero at bit 6
// [R17] event sets pending; cleared on routine entry or by writing one
// [R18] pending flag reads cleared while its pin is in low level mode
// [R19] two-flop synchroniser, edge found by comparing current and previous
module external_pin_interrupt_sense #(
  parameter int STARTUP_CYCLES = ext_irq_pkg::STARTUP_CYCLES_DEFAULT,
  parameter int WDT_CYCLES = ext_irq_pkg::WDT_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [ext_irq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ext_irq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [ext_irq_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_ext_irq_pin_zero,
  input wire logic i_ext_irq_pin_one,
  input wire logic i_ack_pin_zero,
  input wire logic i_ack_pin_one,
  input wire logic i_sleep_request,
  output logic o_irq_pin_zero,
  output logic o_irq_pin_one,
  output logic o_io_clock_run,
  output logic o_asleep,
  output logic o_wake
);
  localparam int WDT_W = $clog2(WDT_CYCLES + 1);
  localparam int START_W = $clog2(STARTUP_CYCLES + 1);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);
  localparam logic [START_W-1:0] START_LAST = START_W'(STARTUP_CYCLES - 1);
  localparam logic [WDT_W-1:0] WDT_ZERO = '0;
  localparam logic [START_W-1:0] START_ZERO = '0;

  // elaboration checks on the counts
  if (STARTUP_CYCLES < 1) begin : bad_startup
    $error("STARTUP_CYCLES must be at least one");
  end
  if (WDT_CYCLES < 2) begin : bad_wdt
    $error("WDT_CYCLES must be at least two");
  end

  // ***************************
  // registers and state
  // ***************************
  logic [7:0] mcu_sleep_and_sense_control;
  logic [7:0] general_irq_enable_reg;
  logic [7:0] core_status_reg;
  logic pin_zero_pending;
  logic pin_one_pending;
  ext_irq_pkg::wake_state_type state;
  ext_irq_pkg::wake_state_type next_state;
  logic [WDT_W-1:0] wdt_count;
  logic [START_W-1:0] start_count;

  // ***************************
  // field decode
  // ***************************
  logic [1:0] pin_zero_sense;
  logic [1:0] pin_one_sense;
  logic [2:0] sleep_mode;
  logic sleep_enable_bit;
  logic global_enable;
  logic enable_zero;
  logic enable_one;
  logic level_zero_mode;
  logic level_one_mode;

  assign pin_one_sense = mcu_sleep_and_sense_control[ext_irq_pkg::PIN_ONE_SENSE_HI:
    ext_irq_pkg::PIN_ONE_SENSE_LO]; // R9
  assign pin_zero_sense = mcu_sleep_and_sense_control[ext_irq_pkg::PIN_ZERO_SENSE_HI:
    ext_irq_pkg::PIN_ZERO_SENSE_LO]; // R10
  assign sleep_mode = mcu_sleep_and_sense_control[ext_irq_pkg::SLEEP_MODE_HI:
    ext_irq_pkg::SLEEP_MODE_LO];
  assign sleep_enable_bit = mcu_sleep_and_sense_control[ext_irq_pkg::SLEEP_ENABLE_BIT];
  assign global_enable = core_status_reg[ext_irq_pkg::GLOBAL_ENABLE_BIT];
  assign enable_zero = general_irq_enable_reg[ext_irq_pkg::PIN_ZERO_ENABLE_BIT]; // R16
  assign enable_one = general_irq_enable_reg[ext_irq_pkg::PIN_ONE_ENABLE_BIT]; // R16
  assign level_zero_mode = (pin_zero_sense == ext_irq_pkg::SENSE_LOW);
  assign level_one_mode = (pin_one_sense == ext_irq_pkg::SENSE_LOW);

  // ***************************
  // pin sensing
  // ***************************
  // io clock gated in all sleep modes but idle
  logic io_run;
  logic sleeping;
  assign sleeping = (state != ext_irq_pkg::ST_AWAKE);
  assign io_run = !(sleeping && sleep_mode != ext_irq_pkg::SLEEP_IDLE); // R5

  // pins feed straight in, the port direction never masks them
  logic level_zero;
  logic level_one;
  logic event_zero;
  logic event_one;
  pin_sense_unit sense_zero (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_pin(i_ext_irq_pin_zero), // R1
    .i_sense(pin_zero_sense),
    .i_io_run(io_run),
    .o_level(level_zero),
    .o_event(event_zero)
  );
  pin_sense_unit sense_one (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_pin(i_ext_irq_pin_one), // R1
    .i_sense(pin_one_sense),
    .i_io_run(io_run),
    .o_level(level_one),
    .o_event(event_one)
  );

  // ***************************
  // bus decode
  // ***************************
  logic write_control;
  logic write_enable;
  logic write_pending;
  logic write_core;
  logic clear_zero;
  logic clear_one;
  assign write_control = i_write && (i_addr == ext_irq_pkg::ADDR_CONTROL);
  assign write_enable = i_write && (i_addr == ext_irq_pkg::ADDR_ENABLE);
  assign write_pending = i_write && (i_addr == ext_irq_pkg::ADDR_PENDING);
  assign write_core = i_write && (i_addr == ext_irq_pkg::ADDR_CORE);
  assign clear_zero = i_ack_pin_zero ||
    (write_pending && i_wdata[ext_irq_pkg::PIN_ZERO_PENDING_BIT]); // R17
  assign clear_one = i_ack_pin_one ||
    (write_pending && i_wdata[ext_irq_pkg::PIN_ONE_PENDING_BIT]); // R17

  // writable registers, reset to zero
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      mcu_sleep_and_sense_control <= ext_irq_pkg::RESET_VALUE; // R15
      general_irq_enable_reg <= ext_irq_pkg::RESET_VALUE;
      core_status_reg <= ext_irq_pkg::RESET_VALUE;
    end else begin
      if (write_control) mcu_sleep_and_sense_control <= i_wdata; // R15
      if (write_enable) general_irq_enable_reg <= i_wdata;
      if (write_core) core_status_reg <= i_wdata;
    end
  end

  // pending flags: an event in the clearing cycle wins; level mode holds clear
  logic next_pending_zero;
  logic next_pending_one;
  assign next_pending_zero = level_zero_mode ? 1'b0 :
    (event_zero || (pin_zero_pending && !clear_zero)); // R17 R18
  assign next_pending_one = level_one_mode ? 1'b0 :
    (event_one || (pin_one_pending && !clear_one)); // R17 R18
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_zero_pending <= 1'b0;
      pin_one_pending <= 1'b0;
    end else begin
      pin_zero_pending <= next_pending_zero;
      pin_one_pending <= next_pending_one;
    end
  end

  // read mux; unmapped addresses read zero, reserved bits read zero
  logic [7:0] pending_view;
  logic [7:0] enable_view;
  logic [7:0] read_value;
  assign pending_view = {pin_one_pending && !level_one_mode,
    pin_zero_pending && !level_zero_mode, 6'h00}; // R18
  assign enable_view = {enable_one, enable_zero, 6'h00}; // R16
  assign read_value = (i_addr == ext_irq_pkg::ADDR_CONTROL) ? mcu_sleep_and_sense_control :
    (i_addr == ext_irq_pkg::ADDR_ENABLE) ? enable_view :
    (i_addr == ext_irq_pkg::ADDR_PENDING) ? pending_view :
    (i_addr == ext_irq_pkg::ADDR_CORE) ? {global_enable, 7'h00} :
    ext_irq_pkg::READ_ZERO;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) o_rdata <= ext_irq_pkg::READ_ZERO;
    else o_rdata <= i_read ? read_value : ext_irq_pkg::READ_ZERO;
  end

  // ***************************
  // requests to the core
  // ***************************
  // level requests are held back while asleep, so a level lost in start-up
  // wakes the part without an interrupt
  logic low_zero;
  logic low_one;
  logic req_zero;
  logic req_one;
  assign low_zero = enable_zero && global_enable && level_zero_mode && !level_zero; // R4
  assign low_one = enable_one && global_enable && level_one_mode && !level_one; // R4
  assign req_zero = global_enable && enable_zero && (level_zero_mode ?
    (!level_zero && !sleeping) : pin_zero_pending); // R2 R11
  assign req_one = global_enable && enable_one && (level_one_mode ?
    (!level_one && !sleeping) : pin_one_pending); // R2 R11 R14

  // ***************************
  // sleep and wake sequencer
  // ***************************
  logic wdt_tick;
  logic any_low;
  logic start_done;
  assign wdt_tick = (wdt_count == WDT_LAST);
  assign any_low = low_zero || low_one;
  assign start_done = (start_count == START_ZERO);

  // watchdog oscillator modelled as an enable divided off the clock
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) wdt_count <= WDT_ZERO;
    else wdt_count <= wdt_tick ? WDT_ZERO : wdt_count + WDT_W'(1);
  end

  // next state
  always_comb begin
    next_state = state;
    case (state)
      ext_irq_pkg::ST_AWAKE: begin
        if (i_sleep_request && sleep_enable_bit) next_state = ext_irq_pkg::ST_ASLEEP;
      end
      ext_irq_pkg::ST_ASLEEP: begin
        if (sleep_mode == ext_irq_pkg::SLEEP_IDLE) begin
          if (req_zero || req_one || any_low) next_state = ext_irq_pkg::ST_STARTUP;
        end else if (any_low) begin
          next_state = ext_irq_pkg::ST_SAMPLE_ONE; // R4
        end
      end
      ext_irq_pkg::ST_SAMPLE_ONE: begin
        if (wdt_tick) next_state = any_low ? ext_irq_pkg::ST_SAMPLE_TWO :
          ext_irq_pkg::ST_ASLEEP; // R6
      end
      ext_irq_pkg::ST_SAMPLE_TWO: begin
        if (wdt_tick) next_state = any_low ? ext_irq_pkg::ST_STARTUP :
          ext_irq_pkg::ST_ASLEEP; // R6 R7
      end
      ext_irq_pkg::ST_STARTUP: begin
        if (start_done) next_state = ext_irq_pkg::ST_AWAKE; // R7 R8
      end
      default: next_state = ext_irq_pkg::ST_AWAKE;
    endcase
  end

  // state and start-up counter
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ext_irq_pkg::ST_AWAKE;
      start_count <= START_LAST;
    end else begin
      state <= next_state;
      if (state != ext_irq_pkg::ST_STARTUP) start_count <= START_LAST;
      else if (!start_done) start_count <= start_count - START_W'(1);
    end
  end

  // registered outputs
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_pin_zero <= 1'b0;
      o_irq_pin_one <= 1'b0;
      o_io_clock_run <= 1'b1;
      o_asleep <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_irq_pin_zero <= req_zero; // R11
      o_irq_pin_one <= req_one; // R11
      o_io_clock_run <= io_run; // R5
      o_asleep <= sleeping;
      o_wake <= (state == ext_irq_pkg::ST_STARTUP) && start_done; // R7
    end
  end

  // ***************************
  // checks
  // ***************************
  sequence double_low_s;
    (state == ext_irq_pkg::ST_SAMPLE_TWO && wdt_tick && any_low);
  endsequence
  sequence startup_end_s;
    (state == ext_irq_pkg::ST_STARTUP && start_done);
  endsequence

  irq_gated_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R11
    o_irq_pin_zero |-> ($past(global_enable) && $past(enable_zero)))
    else $error("pin zero request without enables");
  level_request_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R2
    (global_enable && enable_one && level_one_mode && !level_one && !sleeping)
    |=> o_irq_pin_one) else $error("low level on pin one not requested");
  pending_set_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R17
    (event_zero && !level_zero_mode) |=> pin_zero_pending)
    else $error("event lost on pin zero");
  level_clear_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R18
    $past(level_one_mode) |-> !pin_one_pending)
    else $error("pending set in low level mode");
  stopped_no_pend_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R3
    (!io_run && !pin_one_pending) |=> !pin_one_pending)
    else $error("pending set with io clock stopped");
  clock_gating_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R5
    (sleeping && sleep_mode != ext_irq_pkg::SLEEP_IDLE) |=> !o_io_clock_run)
    else $error("io clock runs in deep sleep");
  double_sample_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R6
    double_low_s |=> (state == ext_irq_pkg::ST_STARTUP))
    else $error("double low sample did not start up");
  wake_pulse_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R7
    startup_end_s |=> (o_wake && state == ext_irq_pkg::ST_AWAKE))
    else $error("no wake at end of start-up");
  sleep_no_level_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R8
    (sleeping && level_zero_mode) |=> !o_irq_pin_zero)
    else $error("level request raised while asleep");
  rdata_delay_a: assert property (@(posedge i_clock) disable iff (!i_rstn) // R15
    (i_read && i_addr == ext_irq_pkg::ADDR_CONTROL) |=>
    (o_rdata == $past(mcu_sleep_and_sense_control)))
    else $error("control read mismatch");
endmodule
`default_nettype wire

// ===== bench/ext_pin_source.sv
// model of an outside source driving one interrupt pin
`timescale 1ns/10ps
`default_nettype none
module ext_pin_source (
  input wire logic i_clock,
  output logic o_pin
);
  // idle high: the pin is pulled up, so a released source reads high
  initial begin
    o_pin = 1'b1;
  end

  // a level is applied just after a rising edge and held until changed
  task automatic drive(input logic level);
    @(posedge i_clock);
    o_pin <= level;
  endtask

  // low pulse of whole cycles; callers keep it at two or more to be caught
  task automatic pulse_low(input int cycles);
    drive(1'b0);
    repeat (cycles) @(posedge i_clock);
    o_pin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== bench/external_pin_interrupt_sense_bench.sv
// self-checking bench for the external pin interrupt sense block
`timescale 1ns/10ps
`default_nettype none
module external_pin_interrupt_sense_bench;
  logic i_clock;
  logic i_rstn;
  logic [ext_irq_pkg::ADDR_W-1:0] i_addr;
  logic [ext_irq_pkg::DATA_W-1:0] i_wdata;
  logic i_write;
  logic i_read;
  logic [ext_irq_pkg::DATA_W-1:0] o_rdata;
  logic i_ack_pin_zero;
  logic i_ack_pin_one;
  logic i_sleep_request;
  logic o_irq_pin_zero;
  logic o_irq_pin_one;
  logic o_io_clock_run;
  logic o_asleep;
  logic o_wake;
  wire logic pin_zero;
  wire logic pin_one;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;

  // short counts keep sleep and wake-up sequences brief
  external_pin_interrupt_sense #(.STARTUP_CYCLES(4), .WDT_CYCLES(3)) u_dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_ext_irq_pin_zero(pin_zero), .i_ext_irq_pin_one(pin_one),
    .i_ack_pin_zero(i_ack_pin_zero), .i_ack_pin_one(i_ack_pin_one),
    .i_sleep_request(i_sleep_request), .o_irq_pin_zero(o_irq_pin_zero),
    .o_irq_pin_one(o_irq_pin_one), .o_io_clock_run(o_io_clock_run),
    .o_asleep(o_asleep), .o_wake(o_wake));
  ext_pin_source u_src0 (.i_clock(i_clock), .o_pin(pin_zero));
  ext_pin_source u_src1 (.i_clock(i_clock), .o_pin(pin_one));

  // ***************************
  // helpers
  // ***************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // sample a little after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic ack(input int p);
    @(posedge i_clock);
    if (p == 0) i_ack_pin_zero <= 1'b1;
    else i_ack_pin_one <= 1'b1;
    @(posedge i_clock);
    i_ack_pin_zero <= 1'b0;
    i_ack_pin_one <= 1'b0;
  endtask
  task automatic set_pin(input int p, input logic v);
    if (p == 0) u_src0.drive(v);
    else u_src1.drive(v);
  endtask
  function automatic logic irq(input int p);
    return (p == 0) ? o_irq_pin_zero : o_irq_pin_one;
  endfunction
  // one-cycle sleep instruction, then confirm the sequencer left awake
  task automatic sleep_now;
    @(posedge i_clock);
    i_sleep_request <= 1'b1;
    @(posedge i_clock);
    i_sleep_request <= 1'b0;
    tick(3);
    chk(8'(o_asleep), 8'h01, "asleep");
  endtask
  // bounded wait for the one-cycle wake pulse, polled every cycle
  task automatic wait_wake;
    int n;
    n = 0;
    while (o_wake !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk(8'(o_wake), 8'h01, "wake pulse");
  endtask

  // ***************************
  // scenarios
  // ***************************
  task automatic test_registers;
    logic [7:0] d;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      chk(d, ext_irq_pkg::RESET_VALUE, "reset value");
    end
    wr(ext_irq_pkg::ADDR_CONTROL, 8'h5A);
    rd(ext_irq_pkg::ADDR_CONTROL, d);
    chk(d, 8'h5A, "control readback");
    wr(ext_irq_pkg::ADDR_ENABLE, 8'hFF);
    rd(ext_irq_pkg::ADDR_ENABLE, d);
    chk(d, 8'hC0, "enable bits");
    wr(3'h5, 8'hFF);
    rd(3'h5, d);
    chk(d, ext_irq_pkg::READ_ZERO, "unmapped read");
    wr(ext_irq_pkg::ADDR_CORE, 8'h80);
    $display("test registers done");
  endtask

  // every edge mode on both pins; clear by write-one in change mode, else by ack
  task automatic test_edges;
    logic [7:0] d;
    logic [1:0] s;
    for (int p = 0; p < 2; p++) begin
      for (int m = 1; m < 4; m++) begin
        s = m[1:0];
        wr(ext_irq_pkg::ADDR_CONTROL, 8'(s) << (2 * p));
        wr(ext_irq_pkg::ADDR_PENDING, 8'hC0);
        set_pin(p, 1'b0);
        tick(6);
        chk(8'(irq(p)), 8'(s != ext_irq_pkg::SENSE_RISE), "after fall");
        set_pin(p, 1'b1);
        tick(6);
        chk(8'(irq(p)), 8'h01, "after rise");
        rd(ext_irq_pkg::ADDR_PENDING, d);
        chk(d, (p == 0) ? 8'h40 : 8'h80, "pending set");
        if (s == ext_irq_pkg::SENSE_ANY) wr(ext_irq_pkg::ADDR_PENDING, d);
        else ack(p);
        tick(3);
        chk(8'(irq(p)), 8'h00, "request cleared");
      end
    end
    $display("test edges done");
  endtask

  task automatic test_masking;
    logic [7:0] d;
    wr(ext_irq_pkg::ADDR_CONTROL, 8'h02);
    wr(ext_irq_pkg::ADDR_CORE, 8'h00);
    u_src0.pulse_low(2);
    tick(6);
    chk(8'(o_irq_pin_zero), 8'h00, "global mask");
    rd(ext_irq_pkg::ADDR_PENDING, d);
    chk(d, 8'h40, "short pulse caught");
    wr(ext_irq_pkg::ADDR_ENABLE, 8'h80);
    wr(ext_irq_pkg::ADDR_CORE, 8'h80);
    tick(3);
    chk(8'(o_irq_pin_zero), 8'h00, "pin mask");
    wr(ext_irq_pkg::ADDR_ENABLE, 8'hC0);
    tick(3);
    chk(8'(o_irq_pin_zero), 8'h01, "unmasked");
    ack(0);
    $display("test masking done");
  endtask

  task automatic test_levels;
    logic [7:0] d;
    wr(ext_irq_pkg::ADDR_CONTROL, 8'h00);
    set_pin(1, 1'b0);
    tick(5);
    chk(8'(o_irq_pin_one), 8'h01, "level request");
    tick(20);
    chk(8'(o_irq_pin_one), 8'h01, "level held");
    rd(ext_irq_pkg::ADDR_PENDING, d);
    chk(d, 8'h00, "pending in level mode");
    set_pin(1, 1'b1);
    tick(5);
    chk(8'(o_irq_pin_one), 8'h00, "level released");
    $display("test levels done");
  endtask

  // power-down: edges ignored, a held low level wakes and then requests
  task automatic test_sleep;
    logic [7:0] d;
    wr(ext_irq_pkg::ADDR_CONTROL, 8'hAC);
    sleep_now();
    chk(8'(o_io_clock_run), 8'h00, "io clock stopped");
    u_src1.pulse_low(3);
    tick(6);
    rd(ext_irq_pkg::ADDR_PENDING, d);
    chk(d, 8'h00, "no edge while stopped");
    set_pin(0, 1'b0);
    wait_wake();
    tick(2);
    chk(8'(o_asleep), 8'h00, "awake");
    chk(8'(o_irq_pin_zero), 8'h01, "request after wake");
    set_pin(0, 1'b1);
    tick(5);
    chk(8'(o_irq_pin_zero), 8'h00, "request gone");
    $display("test sleep done");
  endtask

  // idle keeps edges alive; in power-down a single low sample is rejected,
  // and a low that ends during start-up wakes with no request
  task automatic test_wake_paths;
    int n;
    wr(ext_irq_pkg::ADDR_CONTROL, 8'h8A);
    sleep_now();
    chk(8'(o_io_clock_run), 8'h01, "io clock in idle");
    u_src1.pulse_low(2);
    wait_wake();
    tick(2);
    chk(8'(o_irq_pin_one), 8'h01, "edge request after idle");
    ack(1);
    wr(ext_irq_pkg::ADDR_CONTROL, 8'hA8);
    sleep_now();
    u_src0.pulse_low(2);
    tick(20);
    chk(8'(o_asleep), 8'h01, "single low sample ignored");
    set_pin(0, 1'b0);
    n = 0;
    // start-up is only visible inside, so the release is timed off the state
    while (u_dut.state !== ext_irq_pkg::ST_STARTUP && n < 100) begin
      tick(1);
      n++;
    end
    set_pin(0, 1'b1);
    wait_wake();
    tick(2);
    chk(8'(o_asleep), 8'h00, "awake without level");
    chk(8'(o_irq_pin_zero), 8'h00, "no request after lost level");
    $display("test wake paths done");
  endtask

  // ***************************
  // run control
  // ***************************
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // the whole run needs about four hundred cycles; fifty times that means a hang
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    i_rstn = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_write = 1'b0;
    i_read = 1'b0;
    i_ack_pin_zero = 1'b0;
    i_ack_pin_one = 1'b0;
    i_sleep_request = 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    test_registers();
    test_edges();
    test_masking();
    test_levels();
    test_sleep();
    test_wake_paths();
    test_done();
  end
endmodule
`default_nettype wire
